// ===== core/fmc_pkg.sv
// shared constants, register map and carrier types of the fan monitor configuration/status bank
package fmc_pkg;

   // register map
   localparam logic [7:0] ADDR_PART_ID = 8'h3D;
   localparam logic [7:0] ADDR_MAKER_ID = 8'h3E;
   localparam logic [7:0] ADDR_REVISION = 8'h3F;
   localparam logic [7:0] ADDR_MAIN_CFG = 8'h40;
   localparam logic [7:0] ADDR_STAT1 = 8'h41;
   localparam logic [7:0] ADDR_STAT2 = 8'h42;

   // identification values, arbitrary neutral codes
   localparam logic [7:0] PART_ID_VAL = 8'h5A;
   localparam logic [7:0] MAKER_ID_VAL = 8'h3C;
   localparam logic [7:0] REVISION_VAL = 8'h01;

   // main configuration fields
   localparam int CFG_RUN_BIT = 0;
   localparam int CFG_TIMEOUT_DIS_BIT = 3;
   localparam int CFG_LOCK_BIT = 4;
   localparam int CFG_QUICK_BIT = 5;
   localparam int CFG_FREQ_RANGE_BIT = 6;
   localparam int CFG_PIN_FUNC_BIT = 7;
   localparam logic [7:0] CFG_RESET = 8'h01;
   localparam logic [7:0] STAT_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // power-up limits used while monitoring runs on defaults
   localparam logic [7:0] TEMP_HIGH_DFLT = 8'h7F;
   localparam logic [7:0] TEMP_LOW_DFLT = 8'h81;
   localparam logic [7:0] TEMP_START_DFLT = 8'h5A;
   localparam logic [15:0] TACH_MIN_DFLT = 16'hFFFF;
   localparam logic [15:0] TACH_MAX_DFLT = 16'h0000;

   localparam int NUM_TEMP = 10;
   localparam int NUM_FAN = 4;
   localparam int STAT1_TEMPS = 7;

   // serial link
   localparam logic [6:0] DEV_ADDR = 7'h2C;

   // timing
   localparam int CLK_HZ = 50_000_000;
   localparam int SAMPLE_SLOW_MS = 1000;
   localparam int SAMPLE_FAST_MS = 250;
   localparam int BUS_TIMEOUT_MS = 25;
   localparam int SAMPLE_SLOW_CYC = (CLK_HZ / 1000) * SAMPLE_SLOW_MS;
   localparam int SAMPLE_FAST_CYC = (CLK_HZ / 1000) * SAMPLE_FAST_MS;
   localparam int BUS_TIMEOUT_CYC = (CLK_HZ / 1000) * BUS_TIMEOUT_MS;

   typedef struct packed
   {
      logic signed [7:0] reading;
      logic signed [7:0] low_limit;
      logic signed [7:0] high_limit;
      logic signed [7:0] start_thr;
   } fmc_temp_chan_t;

   typedef struct packed
   {
      logic [15:0] count;
      logic [15:0] min_limit;
      logic [15:0] max_limit;
   } fmc_fan_chan_t;

   typedef struct packed
   {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } fmc_reg_req_t;

   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_ADDR_ACK = 3'b010,
      ST_RX = 3'b011,
      ST_RX_ACK = 3'b100,
      ST_TX = 3'b101,
      ST_TX_ACK = 3'b110
   } fmc_link_state_t;

endpackage : fmc_pkg

// ===== core/fmc_link.sv
// two-wire serial slave engine turning bus traffic into register reads and writes
`timescale 1ns/10ps
module fmc_link #(
   parameter int TIMEOUT_CYC = fmc_pkg::BUS_TIMEOUT_CYC
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic timeout_disable,
   input wire logic [7:0] rd_data,
   output fmc_pkg::fmc_reg_req_t req
);

   localparam int TOW = $clog2(TIMEOUT_CYC + 1);

   logic [1:0] scl_sync_r;
   logic [1:0] sda_sync_r;
   logic scl_d_r;
   logic sda_d_r;
   logic scl_s;
   logic sda_s;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic [TOW-1:0] to_cnt_r;
   logic to_hit;
   fmc_pkg::fmc_link_state_t state_r;
   logic [7:0] shift_r;
   logic [2:0] cnt_r;
   logic byte_done_r;
   logic is_read_r;
   logic got_ptr_r;
   logic ack_ok_r;
   logic [7:0] ptr_r;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers; first stage feeds only the second
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         scl_sync_r <= 2'b11;
         sda_sync_r <= 2'b11;
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end
      else
      begin
         scl_sync_r <= {scl_sync_r[0], scl_i};
         sda_sync_r <= {sda_sync_r[0], sda_i};
         scl_d_r <= scl_sync_r[1];
         sda_d_r <= sda_sync_r[1];
      end
   end

   // edges and bus conditions seen on the synchronised lines
   assign scl_s = scl_sync_r[1];
   assign sda_s = sda_sync_r[1];
   assign scl_rise = scl_s & ~scl_d_r;
   assign scl_fall = ~scl_s & scl_d_r;
   assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
   assign stop_det = scl_s & scl_d_r & ~sda_d_r & sda_s;
   assign to_hit = (to_cnt_r == TOW'(TIMEOUT_CYC - 1));

   ////////////////////////////////////////////////////////////////////////////
   // clock-low timeout; frees the bus if a host dies mid-transfer
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         to_cnt_r <= '0;
      else if (state_r == fmc_pkg::ST_IDLE || scl_s || timeout_disable)
         to_cnt_r <= '0;
      else if (!to_hit)
         to_cnt_r <= TOW'(to_cnt_r + 1'b1);
   end

   // open-drain data line only ever pulls low
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         sda_o <= 1'b0;
      else
         sda_o <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // byte engine: address, pointer byte, then auto-incrementing data
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_r <= fmc_pkg::ST_IDLE;
         shift_r <= 8'h00;
         cnt_r <= 3'h0;
         byte_done_r <= 1'b0;
         is_read_r <= 1'b0;
         got_ptr_r <= 1'b0;
         ack_ok_r <= 1'b0;
         ptr_r <= 8'h00;
         sda_oe <= 1'b0;
         req <= '0;
      end
      else
      begin
         req.wr <= 1'b0;
         req.rd <= 1'b0;
         if (start_det)
         begin
            state_r <= fmc_pkg::ST_ADDR;
            cnt_r <= 3'h0;
            byte_done_r <= 1'b0;
            got_ptr_r <= 1'b0;
            sda_oe <= 1'b0;
         end
         else if (stop_det || to_hit)
         begin
            state_r <= fmc_pkg::ST_IDLE;
            sda_oe <= 1'b0;
         end
         else
         begin
            case (state_r)
               fmc_pkg::ST_ADDR, fmc_pkg::ST_RX:
               begin
                  if (scl_rise)
                  begin
                     shift_r <= {shift_r[6:0], sda_s};
                     cnt_r <= 3'(cnt_r + 3'h1);
                     byte_done_r <= (cnt_r == 3'h7);
                  end
                  else if (scl_fall && byte_done_r)
                  begin
                     byte_done_r <= 1'b0;
                     if (state_r == fmc_pkg::ST_ADDR)
                     begin
                        if (shift_r[7:1] == fmc_pkg::DEV_ADDR)
                        begin
                           is_read_r <= shift_r[0];
                           sda_oe <= 1'b1;
                           state_r <= fmc_pkg::ST_ADDR_ACK;
                        end
                        else
                           state_r <= fmc_pkg::ST_IDLE; // not our address
                     end
                     else
                     begin
                        sda_oe <= 1'b1;
                        state_r <= fmc_pkg::ST_RX_ACK;
                        if (!got_ptr_r)
                        begin
                           ptr_r <= shift_r;
                           got_ptr_r <= 1'b1;
                        end
                        else
                        begin
                           req.wr <= 1'b1;
                           req.addr <= ptr_r;
                           req.wdata <= shift_r;
                           ptr_r <= 8'(ptr_r + 8'h01);
                        end
                     end
                  end
               end
               fmc_pkg::ST_ADDR_ACK:
               begin
                  if (scl_rise && is_read_r)
                  begin
                     req.rd <= 1'b1;
                     req.addr <= ptr_r;
                     ptr_r <= 8'(ptr_r + 8'h01);
                  end
                  else if (scl_fall)
                  begin
                     cnt_r <= 3'h0;
                     if (is_read_r)
                     begin
                        shift_r <= rd_data;
                        sda_oe <= ~rd_data[7];
                        state_r <= fmc_pkg::ST_TX;
                     end
                     else
                     begin
                        sda_oe <= 1'b0;
                        state_r <= fmc_pkg::ST_RX;
                     end
                  end
               end
               fmc_pkg::ST_RX_ACK:
               begin
                  if (scl_fall)
                  begin
                     sda_oe <= 1'b0;
                     cnt_r <= 3'h0;
                     state_r <= fmc_pkg::ST_RX;
                  end
               end
               fmc_pkg::ST_TX:
               begin
                  if (scl_rise)
                  begin
                     cnt_r <= 3'(cnt_r + 3'h1);
                     byte_done_r <= (cnt_r == 3'h7);
                  end
                  else if (scl_fall)
                  begin
                     if (byte_done_r)
                     begin
                        byte_done_r <= 1'b0;
                        sda_oe <= 1'b0; // let the host drive its acknowledge
                        state_r <= fmc_pkg::ST_TX_ACK;
                     end
                     else
                     begin
                        shift_r <= {shift_r[6:0], 1'b0};
                        sda_oe <= ~shift_r[6];
                     end
                  end
               end
               fmc_pkg::ST_TX_ACK:
               begin
                  if (scl_rise)
                  begin
                     ack_ok_r <= ~sda_s;
                     if (!sda_s)
                     begin
                        req.rd <= 1'b1;
                        req.addr <= ptr_r;
                        ptr_r <= 8'(ptr_r + 8'h01);
                     end
                  end
                  else if (scl_fall)
                  begin
                     cnt_r <= 3'h0;
                     if (ack_ok_r)
                     begin
                        shift_r <= rd_data;
                        sda_oe <= ~rd_data[7];
                        state_r <= fmc_pkg::ST_TX;
                     end
                     else
                        state_r <= fmc_pkg::ST_IDLE;
                  end
               end
               default:
                  state_r <= fmc_pkg::ST_IDLE;
            endcase
         end
      end
   end

endmodule : fmc_link

// ===== core/fmc_cfg_status_regs.sv
// configuration, identification and fault status register bank of the fan monitor
// Notes on behaviour
// - three read-only identity registers give part, maker and revision codes.
// - run bit set uses programmed limits; cleared falls back to power-up limits.
// - clearing the run bit leaves programmed limits untouched.
// - configuration bit three set turns off the bus timeout.
// - lock bit is write-once; afterwards lockable registers ignore writes until power cycle.
// - bit five picks tach sampling once per second or every 250 ms.
// - bit six picks high or low frequency fan drive range.
// - bit seven picks shared pin role: override input or sensor start pulse.
// - configuration register powers up at 0x01.
// - first status bits 0-6 latch faults of remote channels 1-7.
// - a fault bit clears on status read only once its fault is gone.
// - first status bit 7 is the OR of all second status bits.
// - second status bits 0-2 latch faults of remote channels 8-10.
// - second status bit 3 says all temperatures are below fan start thresholds.
// - second status bits 4-7 latch speed faults of fans 1-4.
// - both status registers power up at 0x00.
// - temperature fault when reading above high limit or at/below low limit.
// - tach count above minimum limit is slow, below maximum limit is fast.
`timescale 1ns/10ps
module fmc_cfg_status_regs #(
   parameter int SAMPLE_SLOW_CYC = fmc_pkg::SAMPLE_SLOW_CYC,
   parameter int SAMPLE_FAST_CYC = fmc_pkg::SAMPLE_FAST_CYC,
   parameter int BUS_TIMEOUT_CYC = fmc_pkg::BUS_TIMEOUT_CYC
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire fmc_pkg::fmc_temp_chan_t [fmc_pkg::NUM_TEMP-1:0] temp_in,
   input wire fmc_pkg::fmc_fan_chan_t [fmc_pkg::NUM_FAN-1:0] fan_in,
   output logic monitor_run,
   output logic bus_timeout_disable,
   output logic lock_active,
   output logic quick_speed_sampling,
   output logic drive_freq_range,
   output logic shared_pin_function,
   output logic speed_sample_tick
);

   localparam int SW = $clog2(SAMPLE_SLOW_CYC + 1);

   fmc_pkg::fmc_reg_req_t link_req;
   logic [7:0] rd_data_r;
   logic [7:0] cfg_r;
   logic [fmc_pkg::NUM_TEMP-1:0] temp_flt_r;
   logic [fmc_pkg::NUM_TEMP-1:0] temp_cond;
   logic [fmc_pkg::NUM_TEMP-1:0] temp_cool;
   logic [fmc_pkg::NUM_TEMP-1:0] temp_clr;
   logic [fmc_pkg::NUM_FAN-1:0] fan_flt_r;
   logic [fmc_pkg::NUM_FAN-1:0] fan_cond;
   logic all_cool_r;
   logic [7:0] stat1;
   logic [7:0] stat2;
   logic rd_clr1;
   logic rd_clr2;
   logic [SW-1:0] sample_cnt_r;
   logic [SW-1:0] sample_period;

   // all checks of the bank run on the system clock and sleep in reset
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);

   // set wins over a read clear, so an event in the clearing cycle survives
   function automatic logic sticky_nxt(input logic cur, input logic cond, input logic clr);
      sticky_nxt = cond | (cur & ~clr);
   endfunction : sticky_nxt

   // which status read clears a given temperature channel; strobes passed in so callers see sampled values
   function automatic logic rd_clr_for(input int ch, input logic clr1, input logic clr2);
      rd_clr_for = (ch < fmc_pkg::STAT1_TEMPS) ? clr1 : clr2;
   endfunction : rd_clr_for

   ////////////////////////////////////////////////////////////////////////////
   // serial link engine
   fmc_link #(
      .TIMEOUT_CYC(BUS_TIMEOUT_CYC)
   ) fmc_link_i (
      .mclk(mclk),
      .rstn(rstn),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .sda_o(sda_o),
      .sda_oe(sda_oe),
      .timeout_disable(cfg_r[fmc_pkg::CFG_TIMEOUT_DIS_BIT]),
      .rd_data(rd_data_r),
      .req(link_req)
   );

   ////////////////////////////////////////////////////////////////////////////
   // main configuration; reserved bits are stored as written by the host
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         cfg_r <= fmc_pkg::CFG_RESET;
      else if (link_req.wr && link_req.addr == fmc_pkg::ADDR_MAIN_CFG && !cfg_r[fmc_pkg::CFG_LOCK_BIT])
         cfg_r <= link_req.wdata;
   end

   // configuration fields driven straight from the register
   assign monitor_run = cfg_r[fmc_pkg::CFG_RUN_BIT];
   assign bus_timeout_disable = cfg_r[fmc_pkg::CFG_TIMEOUT_DIS_BIT];
   assign lock_active = cfg_r[fmc_pkg::CFG_LOCK_BIT];
   assign quick_speed_sampling = cfg_r[fmc_pkg::CFG_QUICK_BIT];
   assign drive_freq_range = cfg_r[fmc_pkg::CFG_FREQ_RANGE_BIT];
   assign shared_pin_function = cfg_r[fmc_pkg::CFG_PIN_FUNC_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // tach sampling tick; only the period changes, limits stay external
   assign sample_period = quick_speed_sampling ? SW'(SAMPLE_FAST_CYC - 1) : SW'(SAMPLE_SLOW_CYC - 1);

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         sample_cnt_r <= '0;
         speed_sample_tick <= 1'b0;
      end
      else if (sample_cnt_r >= sample_period)
      begin
         sample_cnt_r <= '0;
         speed_sample_tick <= 1'b1;
      end
      else
      begin
         sample_cnt_r <= SW'(sample_cnt_r + 1'b1);
         speed_sample_tick <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // limit comparisons; programmed limits are only selected, never overwritten
   for (genvar t = 0; t < fmc_pkg::NUM_TEMP; t++)
   begin : g_temp
      logic signed [7:0] eff_hi;
      logic signed [7:0] eff_lo;
      logic signed [7:0] eff_start;
      assign eff_hi = monitor_run ? temp_in[t].high_limit : fmc_pkg::TEMP_HIGH_DFLT;
      assign eff_lo = monitor_run ? temp_in[t].low_limit : fmc_pkg::TEMP_LOW_DFLT;
      assign eff_start = monitor_run ? temp_in[t].start_thr : fmc_pkg::TEMP_START_DFLT;
      assign temp_cond[t] = (temp_in[t].reading > eff_hi) || (temp_in[t].reading <= eff_lo);
      assign temp_cool[t] = temp_in[t].reading < eff_start;
      assign temp_clr[t] = rd_clr_for(t, rd_clr1, rd_clr2);

      chk_temp_set: assert property (temp_cond[t] |=> temp_flt_r[t])
         else $error("temperature fault not latched");
      chk_temp_hold: assert property (temp_flt_r[t] && !temp_clr[t] |=> temp_flt_r[t])
         else $error("temperature fault dropped without read");
      chk_temp_clear: assert property (temp_flt_r[t] && temp_clr[t] && !temp_cond[t] |=> !temp_flt_r[t])
         else $error("temperature fault not cleared by read");
   end

   for (genvar f = 0; f < fmc_pkg::NUM_FAN; f++)
   begin : g_fan
      logic [15:0] eff_min;
      logic [15:0] eff_max;
      assign eff_min = monitor_run ? fan_in[f].min_limit : fmc_pkg::TACH_MIN_DFLT;
      assign eff_max = monitor_run ? fan_in[f].max_limit : fmc_pkg::TACH_MAX_DFLT;
      assign fan_cond[f] = (fan_in[f].count > eff_min) || (fan_in[f].count < eff_max);

      chk_fan_latch: assert property (fan_cond[f] |=> fan_flt_r[f])
         else $error("fan fault not latched");
      chk_fan_readclr: assert property (fan_flt_r[f] ##0 (rd_clr2 && fan_cond[f]) |=> fan_flt_r[f])
         else $error("fan fault cleared while still present");
   end

   ////////////////////////////////////////////////////////////////////////////
   // fault latches cleared by a status read only once the fault subsided
   assign rd_clr1 = link_req.rd && (link_req.addr == fmc_pkg::ADDR_STAT1);
   assign rd_clr2 = link_req.rd && (link_req.addr == fmc_pkg::ADDR_STAT2);

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         temp_flt_r <= '0;
      else
         for (int t = 0; t < fmc_pkg::NUM_TEMP; t++)
            temp_flt_r[t] <= sticky_nxt(temp_flt_r[t], temp_cond[t], temp_clr[t]);
   end

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         fan_flt_r <= '0;
      else
         for (int f = 0; f < fmc_pkg::NUM_FAN; f++)
            fan_flt_r[f] <= sticky_nxt(fan_flt_r[f], fan_cond[f], rd_clr2);
   end

   // the all-cool flag tracks the live comparison, reads do not touch it
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         all_cool_r <= 1'b0;
      else
         all_cool_r <= &temp_cool;
   end

   // status images; bit 7 of the first saves software a second read
   assign stat2 = {fan_flt_r, all_cool_r, temp_flt_r[fmc_pkg::NUM_TEMP-1:fmc_pkg::STAT1_TEMPS]};
   assign stat1 = {|stat2, temp_flt_r[fmc_pkg::STAT1_TEMPS-1:0]};

   ////////////////////////////////////////////////////////////////////////////
   // read data; unmapped offsets read back as zero
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         rd_data_r <= 8'h00;
      else if (link_req.rd)
      begin
         if (link_req.addr == fmc_pkg::ADDR_PART_ID)
            rd_data_r <= fmc_pkg::PART_ID_VAL;
         else if (link_req.addr == fmc_pkg::ADDR_MAKER_ID)
            rd_data_r <= fmc_pkg::MAKER_ID_VAL;
         else if (link_req.addr == fmc_pkg::ADDR_REVISION)
            rd_data_r <= fmc_pkg::REVISION_VAL;
         else if (link_req.addr == fmc_pkg::ADDR_MAIN_CFG)
            rd_data_r <= cfg_r;
         else if (link_req.addr == fmc_pkg::ADDR_STAT1)
            rd_data_r <= stat1;
         else if (link_req.addr == fmc_pkg::ADDR_STAT2)
            rd_data_r <= stat2;
         else
            rd_data_r <= fmc_pkg::UNMAPPED_READ;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks on the bank
   sequence s_cfg_write;
      link_req.wr && link_req.addr == fmc_pkg::ADDR_MAIN_CFG;
   endsequence

   sequence s_tick_quiet;
      (!speed_sample_tick)[*8];
   endsequence

   chk_lock_sticky: assert property (lock_active |=> lock_active)
      else $error("lock bit released without power cycle");
   chk_lock_blocks: assert property (lock_active ##0 s_cfg_write |=> $stable(cfg_r))
      else $error("locked configuration was modified");
   chk_cfg_write: assert property (!lock_active ##0 s_cfg_write |=> cfg_r == $past(link_req.wdata))
      else $error("unlocked configuration write not stored");
   chk_summary_bit: assert property (link_req.rd && link_req.addr == fmc_pkg::ADDR_STAT1
                                     |=> rd_data_r[7] == |$past(stat2))
      else $error("summary bit differs from second status OR");
   chk_ident_read: assert property (link_req.rd && link_req.addr == fmc_pkg::ADDR_MAKER_ID
                                    |=> rd_data_r == fmc_pkg::MAKER_ID_VAL)
      else $error("maker identity read wrong");
   chk_cool_follow: assert property (##1 all_cool_r == &$past(temp_cool))
      else $error("all-cool flag does not follow comparison");
   chk_default_limit: assert property (!monitor_run |-> g_temp[0].eff_hi == fmc_pkg::TEMP_HIGH_DFLT)
      else $error("default high limit not in force");
   chk_tick_spacing: assert property (speed_sample_tick |=> s_tick_quiet)
      else $error("sample ticks too close together");

endmodule : fmc_cfg_status_regs

// ===== dv/fmc_host.sv
// serial bus host model for the bank, pull-up on the data wire
`timescale 1ns/10ps
module fmc_host (
   input wire logic mclk,
   input wire logic sda_oe,
   output logic scl,
   output logic sda
);
   logic sda_h = 1'h1;
   initial scl = 1'h1;
   // device only pulls low, so the wire is the and of both parties
   assign sda = sda_h & ~sda_oe;
   task automatic tk(input int n);
      repeat (n) @(posedge mclk);
   endtask : tk
   // data moves one cycle after scl falls so it never looks like a start or stop
   task automatic bt(input logic b, output logic r);
      tk(1);
      sda_h <= b;
      tk(3);
      scl <= 1'h1;
      tk(4);
      r = sda;
      scl <= 1'h0;
   endtask : bt
   task automatic st();
      tk(1);
      sda_h <= 1'h1;
      tk(6);
      scl <= 1'h1;
      tk(4);
      sda_h <= 1'h0;
      tk(4);
      scl <= 1'h0;
   endtask : st
   task automatic sp();
      tk(1);
      sda_h <= 1'h0;
      tk(6);
      scl <= 1'h1;
      tk(4);
      sda_h <= 1'h1;
      tk(4);
   endtask : sp
   task automatic by(input logic [7:0] d, output logic [7:0] q, output logic k);
      for (int i = 7; i >= 0; i--) bt(d[i], q[i]);
      bt(1'h1, k);
   endtask : by
   // the final data byte of a read is refused by leaving the ack bit high
   task automatic xf(input logic [7:0] a, input logic [7:0] d, input logic r, output logic [7:0] q, output logic n);
      logic k0, k1, k2, k3;
      st();
      by({fmc_pkg::DEV_ADDR, 1'h0}, q, k0);
      by(a, q, k1);
      if (r)
      begin
         st();
         by({fmc_pkg::DEV_ADDR, 1'h1}, q, k2);
      end
      by(r ? 8'hFF : d, q, k3);
      sp();
      n = k0 | k1 | (r ? k2 : k3);
   endtask : xf
endmodule : fmc_host

// ===== dv/fmc_cfg_status_regs_test.sv
// self-checking bench of the configuration and status bank
`timescale 1ns/10ps
module fmc_cfg_status_regs_test;
   localparam int SLOW = 40;
   localparam int FAST = 20;
   logic mclk = 1'h0;
   logic rstn = 1'h0;
   logic scl, sda, sda_o, sda_oe, mr, btd, la, qss, dfr, spf, tick;
   fmc_pkg::fmc_temp_chan_t [fmc_pkg::NUM_TEMP-1:0] temp_in;
   fmc_pkg::fmc_fan_chan_t [fmc_pkg::NUM_FAN-1:0] fan_in;
   logic [7:0] co;
   int checks = 0;
   int bad_count = 0;
   fmc_cfg_status_regs #(.SAMPLE_SLOW_CYC(SLOW), .SAMPLE_FAST_CYC(FAST), .BUS_TIMEOUT_CYC(2000)) fmc_cfg_status_regs_i (
      .mclk(mclk), .rstn(rstn), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .temp_in(temp_in),
      .fan_in(fan_in), .monitor_run(mr), .bus_timeout_disable(btd), .lock_active(la), .quick_speed_sampling(qss),
      .drive_freq_range(dfr), .shared_pin_function(spf), .speed_sample_tick(tick));
   fmc_host fmc_host_i (.mclk(mclk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
   // configuration outputs laid out at their register positions
   assign co = {spf, dfr, qss, la, btd, 2'h0, mr};
   always #10 mclk = ~mclk;
   task automatic ck(input logic [8:0] g, input logic [8:0] e);
      checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("Error %0t: got %h expected %h", $time, g, e);
      end
   endtask : ck
   // top bit of each compare is the summed missing acknowledge
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] q;
      logic n;
      fmc_host_i.xf(a, 8'h00, 1'h1, q, n);
      ck({n, q}, {1'h0, e});
   endtask : rd
   task automatic wc(input logic [7:0] d, input logic [7:0] e);
      logic [7:0] q;
      logic n;
      fmc_host_i.xf(fmc_pkg::ADDR_MAIN_CFG, d, 1'h0, q, n);
      ck({n, co}, {1'h0, e & 8'hF9});
   endtask : wc
   // first gap may be cut short by the mode change, so the third is measured
   task automatic tp(input int e);
      int n;
      for (int j = 0; j < 3; j++)
      begin
         n = 0;
         do begin @(posedge mclk); n++; end while (!tick && n < 99);
      end
      ck(9'(n), 9'(e));
   endtask : tp
   task automatic test_done();
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : test_done
   ////////////////////////////////////////////////////////////////
   // quiet channels: inside limits and above the fan start level
   initial
   begin
      for (int i = 0; i < fmc_pkg::NUM_TEMP; i++) temp_in[i] = {8'h30, 8'hF6, 8'h50, 8'h20};
      for (int i = 0; i < fmc_pkg::NUM_FAN; i++) fan_in[i] = {16'h1000, 16'h2000, 16'h0800};
      repeat (16) @(posedge mclk);
      rstn <= 1'h1;
      repeat (4) @(posedge mclk);
      ck({1'h0, co}, 9'h001);
      rd(fmc_pkg::ADDR_MAIN_CFG, 8'h01);
      rd(fmc_pkg::ADDR_STAT1, 8'h00);
      rd(fmc_pkg::ADDR_STAT2, 8'h00);
      rd(fmc_pkg::ADDR_PART_ID, fmc_pkg::PART_ID_VAL);
      rd(fmc_pkg::ADDR_MAKER_ID, fmc_pkg::MAKER_ID_VAL);
      rd(fmc_pkg::ADDR_REVISION, fmc_pkg::REVISION_VAL);
      rd(8'h10, fmc_pkg::UNMAPPED_READ);
      wc(8'hE8, 8'hE8);
      tp(FAST);
      rd(fmc_pkg::ADDR_STAT1, 8'h80);
      rd(fmc_pkg::ADDR_STAT2, 8'h08);
      rd(fmc_pkg::ADDR_STAT2, 8'h08);
      temp_in[0].reading <= 8'h60;
      rd(fmc_pkg::ADDR_STAT1, 8'h00);
      wc(8'h09, 8'h09);
      tp(SLOW);
      rd(fmc_pkg::ADDR_STAT1, 8'h01);
      rd(fmc_pkg::ADDR_STAT1, 8'h01);
      temp_in[0].reading <= 8'h30;
      rd(fmc_pkg::ADDR_STAT1, 8'h01);
      rd(fmc_pkg::ADDR_STAT1, 8'h00);
      temp_in[7].reading <= 8'hF6;
      temp_in[9].reading <= 8'h50;
      fan_in[0].count <= 16'h2000;
      fan_in[2].count <= 16'h2001;
      fan_in[3].count <= 16'h07FF;
      rd(fmc_pkg::ADDR_STAT2, 8'hC1);
      rd(fmc_pkg::ADDR_STAT1, 8'h80);
      temp_in[7].reading <= 8'h30;
      fan_in[2].count <= 16'h1000;
      fan_in[3].count <= 16'h1000;
      rd(fmc_pkg::ADDR_STAT2, 8'hC1);
      rd(fmc_pkg::ADDR_STAT2, 8'h00);
      rd(fmc_pkg::ADDR_STAT1, 8'h00);
      wc(8'h11, 8'h11);
      wc(8'h00, 8'h11);
      rd(fmc_pkg::ADDR_MAIN_CFG, 8'h11);
      test_done();
   end
   // watchdog at 50000 system clocks, about six times the roughly 8200 the sequence needs
   initial
   begin
      #1_000_000;
      bad_count++;
      test_done();
   end
endmodule : fmc_cfg_status_regs_test
